// File: design/dpd_pkg.sv
// Constants and carrier types for the deep power-down command block
package dpd_pkg;
    // Command opcodes
    localparam logic [7:0] DPD_OP_ENTER = 8'hb9;
    localparam logic [7:0] DPD_OP_EXIT = 8'hab;
    localparam logic [7:0] DPD_OP_STATUS = 8'h05;
    localparam logic [7:0] DPD_OP_TABLE = 8'h5a;
    // Status layout
    localparam int DPD_BUSY_BIT = 0;
    // Exit delay
    localparam int DPD_CLK_HZ = 10_000_000;
    localparam int DPD_EXIT_US = 30;
    localparam int DPD_EXIT_CYC = (DPD_EXIT_US * DPD_CLK_HZ + 999_999) / 1_000_000;
    // Parameter doubleword fields
    localparam logic [6:0] DPD_TBL_BASE = 7'h34;
    localparam logic [6:0] DPD_TBL_LAST = 7'h37;
    localparam logic [0:0] DPD_FLD_UNSUP = 1'h0;
    localparam logic [1:0] DPD_FLD_UNIT = 2'h1;
    localparam logic [4:0] DPD_FLD_COUNT = 5'h1d;
    localparam logic [3:0] DPD_FLD_RES_HI = 4'hf;
    localparam logic [1:0] DPD_FLD_POLL = 2'h1;
    localparam logic [1:0] DPD_FLD_RES_LO = 2'h3;
    localparam logic [31:0] DPD_DWORD = {DPD_FLD_UNSUP, DPD_OP_ENTER, DPD_OP_EXIT,
        DPD_FLD_UNIT, DPD_FLD_COUNT, DPD_FLD_RES_HI, DPD_FLD_POLL, DPD_FLD_RES_LO};
    localparam logic [7:0] DPD_READ_NONE = 8'hff;

    // Command request from the serial front end
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [6:0] addr;
    } dpd_cmd_type;

    // Answer byte to the serial front end
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dpd_resp_type;
endpackage

// File: design/dpd_core.sv
// Deep power-down command interpreter with busy status and table read
`timescale 1ns/100ps
module dpd_core #(
    parameter int EXIT_CYC = dpd_pkg::DPD_EXIT_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Decoded command from serial front end
    input wire dpd_pkg::dpd_cmd_type cmd_i,
    // Array operation in progress from the core
    input wire logic array_busy_i,
    // Answer byte
    output dpd_pkg::dpd_resp_type resp_o,
    // Status outputs
    output logic powered_down_o,
    output logic waking_o,
    output logic cmd_accept_o
);
    // Width of the exit delay counter, sized from the delay itself
    localparam int WAIT_W = $clog2(EXIT_CYC + 1);

    // Power states: awake, powered down, and the exit delay
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_DEEP,
        ST_WAKE
    } dpd_state_type;

    // Power state group
    dpd_state_type state_r;
    dpd_state_type state_nxt;

    // Exit delay counter group
    logic [WAIT_W-1:0] wait_r;
    logic [WAIT_W-1:0] wait_nxt;

    // Answer group
    dpd_pkg::dpd_resp_type resp_r;
    dpd_pkg::dpd_resp_type resp_nxt;
    logic accept_r;
    logic accept_nxt;

    // Level output group
    logic powered_down_r;
    logic powered_down_nxt;
    logic waking_r;
    logic waking_nxt;

    // Decoded command strobes
    logic take_any;
    logic take_enter;
    logic take_exit;
    logic take_status;
    logic take_table;

    // Table window helpers and the exit delay done flag
    logic in_table;
    logic wake_done;
    logic [1:0] lane;
    logic [7:0] table_byte;
    logic [31:0] dword;

    // Opcode decode, gated by the power state
    always_comb begin
        take_any = 1'b0;
        take_enter = 1'b0;
        take_exit = 1'b0;
        take_status = 1'b0;
        take_table = 1'b0;
        unique case (state_r)
            ST_ACTIVE: begin
                // Every opcode is taken while awake
                take_any = cmd_i.valid;
                take_enter = cmd_i.valid &&
                    (cmd_i.opcode == dpd_pkg::DPD_OP_ENTER);
                take_status = cmd_i.valid &&
                    (cmd_i.opcode == dpd_pkg::DPD_OP_STATUS);
                take_table = cmd_i.valid &&
                    (cmd_i.opcode == dpd_pkg::DPD_OP_TABLE);
            end
            ST_DEEP: begin
                // Only the exit opcode gets through
                take_exit = cmd_i.valid &&
                    (cmd_i.opcode == dpd_pkg::DPD_OP_EXIT);
                take_any = take_exit;
            end
            ST_WAKE: begin
                // Nothing is taken during the exit delay
                take_any = 1'b0;
            end
            default: begin
                // Illegal state code takes nothing
                take_any = 1'b0;
            end
        endcase
    end

    // Table window and byte lane
    assign dword = dpd_pkg::DPD_DWORD;
    assign lane = cmd_i.addr[1:0];
    assign in_table = (cmd_i.addr >= dpd_pkg::DPD_TBL_BASE) &&
        (cmd_i.addr <= dpd_pkg::DPD_TBL_LAST);

    // Exit delay countdown, loaded by the exit opcode
    always_comb begin
        wait_nxt = wait_r;
        wake_done = (wait_r == '0);
        if (take_exit) begin
            wait_nxt = WAIT_W'(EXIT_CYC - 1);
        end else if (state_r == ST_WAKE && !wake_done) begin
            wait_nxt = wait_r - WAIT_W'(1);
        end
    end

    // Power state transitions
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_ACTIVE: begin
                if (take_enter) begin
                    state_nxt = ST_DEEP;
                end
            end
            ST_DEEP: begin
                if (take_exit) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Decoding resumes once the delay has run out
                if (wake_done) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            default: begin
                // Illegal code falls back to awake
                state_nxt = ST_ACTIVE;
            end
        endcase
    end

    // Answer byte and accept pulse
    always_comb begin
        resp_nxt = '{valid: 1'b0, data: 8'h00};
        accept_nxt = take_any;
        table_byte = dword[lane*$bits(table_byte) +: $bits(table_byte)];
        if (take_status) begin
            // Only the busy bit is set, the rest read zero
            resp_nxt.valid = 1'b1;
            resp_nxt.data[dpd_pkg::DPD_BUSY_BIT] = array_busy_i;
        end else if (take_table) begin
            resp_nxt.valid = 1'b1;
            if (in_table) begin
                resp_nxt.data = table_byte;
            end else begin
                // Outside the window the table reads erased
                resp_nxt.data = dpd_pkg::DPD_READ_NONE;
            end
        end
    end

    // Level outputs follow the next state, so they change with it
    always_comb begin
        powered_down_nxt = (state_nxt == ST_DEEP);
        waking_nxt = (state_nxt == ST_WAKE);
    end

    // Power state register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ST_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Exit delay counter register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_r <= '0;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    // Answer registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            resp_r <= '0;
            accept_r <= 1'b0;
        end else begin
            resp_r <= resp_nxt;
            accept_r <= accept_nxt;
        end
    end

    // Level output registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            powered_down_r <= 1'b0;
            waking_r <= 1'b0;
        end else begin
            powered_down_r <= powered_down_nxt;
            waking_r <= waking_nxt;
        end
    end

    // Outputs straight from their flip-flops
    assign resp_o = resp_r;
    assign cmd_accept_o = accept_r;
    assign powered_down_o = powered_down_r;
    assign waking_o = waking_r;
endmodule

// File: verif/dpd_core_props.sv
// Assertions for the power-down block
`timescale 1ns/100ps
module dpd_core_props #(parameter int EXIT_CYC = 300) (input wire logic clk_sys_i, reset_n_i,
    array_busy_i, powered_down_o, waking_o, cmd_accept_o, input wire dpd_pkg::dpd_cmd_type cmd_i,
    input wire dpd_pkg::dpd_resp_type resp_o);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Command taken awake, asleep, and a table read
    sequence s_tk(op);
        cmd_i.valid && cmd_i.opcode == op && !powered_down_o && !waking_o;
    endsequence
    sequence s_pd(op); cmd_i.valid && cmd_i.opcode == op && powered_down_o; endsequence
    property p_t(a, d);
        s_tk(8'h5a) ##0 cmd_i.addr == 7'h34 + a |=> resp_o == {1'b1, d};
    endproperty
    chk_tbl_b0: assert property (p_t(0, 8'hf7)) else $error("t0");
    chk_tbl_b1: assert property (p_t(1, 8'hbd)) else $error("t1");
    chk_tbl_b2: assert property (p_t(2, 8'hd5)) else $error("t2");
    chk_tbl_b3: assert property (p_t(3, 8'h5c)) else $error("t3");
    chk_enter_dpd: assert property (s_tk(8'hb9) |=> powered_down_o) else $error("e");
    chk_exit_dpd: assert property (s_pd(8'hab) |=> waking_o) else $error("x");
    chk_busy_bit: assert property (s_tk(8'h05)
        |=> resp_o == {8'h80, $past(array_busy_i)}) else $error("b");
    chk_dpd_mute: assert property (cmd_i.valid && powered_down_o && cmd_i.opcode != 8'hab
        |=> !cmd_accept_o) else $error("m");
    // Cycles spent waking
    logic [15:0] wake_cnt;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) wake_cnt <= '0;
        else wake_cnt <= waking_o ? wake_cnt + 16'h0001 : 16'h0000;
    end
    chk_wake_len: assert property ($fell(waking_o) |-> wake_cnt == EXIT_CYC) else $error("w");
    chk_wake_mute: assert property (waking_o && cmd_i.valid |=> !cmd_accept_o) else $error("k");
    chk_tbl_none: assert property (s_tk(8'h5a) ##0 (cmd_i.addr < 7'h34 || cmd_i.addr > 7'h37)
        |=> resp_o == {1'b1, 8'hff}) else $error("n");
    chk_resp_acc: assert property (resp_o.valid |-> cmd_accept_o) else $error("r");
    chk_one_state: assert property (!(powered_down_o && waking_o)) else $error("s");
endmodule
bind dpd_core dpd_core_props #(.EXIT_CYC(EXIT_CYC)) i_dpd_core_props(.*);

// File: verif/dpd_host_model.sv
// Host model driving command pulses
`timescale 1ns/100ps
module dpd_host_model (input wire logic clk_i, output dpd_pkg::dpd_cmd_type cmd_o = '0);
    // One pulse, then idle fields scrambled
    task automatic send(input logic [7:0] op, input logic [6:0] a);
        @(posedge clk_i) #10 cmd_o = '{1'b1, op, a};
        @(posedge clk_i) #10 cmd_o = '{1'b0, ~op, ~a};
    endtask
endmodule

// File: verif/tb_dpd_core.sv
// Bench for the power-down block
`timescale 1ns/100ps
`define C(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD %0t %h %h", $time, a, e); end end
`define S(o, a = 7'h0) i_dpd_host_model.send(o, a)
module tb_dpd_core;
    logic clk_sys_i = 0, reset_n_i = 0, array_busy_i = 0, powered_down_o, waking_o, cmd_accept_o;
    dpd_pkg::dpd_cmd_type cmd_i;
    dpd_pkg::dpd_resp_type resp_o;
    int n_mismatch = 0, compares = 0, cyc = 0;
    dpd_core #(.EXIT_CYC(4)) i_dpd_core(.*);
    dpd_host_model i_dpd_host_model(.clk_i(clk_sys_i), .cmd_o(cmd_i));
    always #50 clk_sys_i = ~clk_sys_i; // Clock
    always @(posedge clk_sys_i) begin // Hang guard
        if (++cyc == 200) n_mismatch++;
        if (cyc == 200) results();
    end
    task automatic results;
        $display("n_mismatch %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin // Table, status, power-down cycle
        repeat (10) @(posedge clk_sys_i);
        #10 reset_n_i = 1;
        `C({powered_down_o, waking_o, cmd_accept_o, resp_o.valid}, 4'h0)
        for (int i = 0; i < 4; i++) begin
            `S(8'h5a, 7'h34 + 7'(i)); `C(resp_o.data, 8'(32'h5cd5bdf7 >> 8 * i))
            array_busy_i = i[0];
            `S(8'h05); `C(resp_o, {8'h80, i[0]})
        end
        `S(8'h5a, 7'h38); `C(resp_o, {1'b1, 8'hff})
        `S(8'h9f); `C({cmd_accept_o, resp_o.valid}, 2'b10)
        `S(8'hb9); `C({cmd_accept_o, powered_down_o}, 2'b11)
        `S(8'h05); `C({cmd_accept_o, resp_o.valid}, 2'b00)
        `S(8'hab); `C({cmd_accept_o, powered_down_o, waking_o}, 3'b101)
        `S(8'h05); `C({cmd_accept_o, waking_o}, 2'b01)
        repeat (2) @(posedge clk_sys_i);
        #10 `C({powered_down_o, waking_o}, 2'b00)
        `S(8'h05); `C(cmd_accept_o, 1'b1)
        `S(8'hb9); reset_n_i = 0;
        @(posedge clk_sys_i) #10 `C({powered_down_o, cmd_accept_o}, 2'b00)
        reset_n_i = 1;
        `S(8'h05); `C({cmd_accept_o, resp_o.valid}, 2'b11)
        results();
    end
endmodule
